//--- hw/aicd_top.sv
// Purpose: receive/transmit interrupt request, acknowledge and daisy chain
// Assumes: all inputs synchronous to ref_clk; causes arrive as pulses
// Notes: serial rate is an enable pulse divided from ref_clk
//
// Summary of operation
// R1: tx chain enable in low grants this device permission to claim chain.
// R2: tx chain enable out low only when input low and no tx pending.
// R3: rx request open-drain, pending from 8 valid causes or parity cause.
// R4: rx acknowledge while request active returns highest-priority rx vector.
// R5: rx chain pair follows same daisy rules, independent of tx.
// R6: each of 3 tx channels drives separate one and zero lines.
// R7: each of 8 rx channels accepts separate one and zero lines.
// R8: reset low puts all registers to defined state; the fifo storage mem_q is not reset.
// R9: host interface and acknowledge timed by system clock.
// R10: serial lines sampled on serial-rate enable, independent timing.
// R11: vector placed on lower eight data bits only.
// R12: tx request has six causes, fifo empty and end per channel.
// R13: transfer ack during chip select access or either acknowledge cycle.
// R14: request released once no cause remains on that path.
`include "aicd_consts.svh"
`timescale 1ns/1ps
module aicd_top #(
    parameter int NUM_TX = `AICD_NUM_TX,
    parameter int NUM_RX = `AICD_NUM_RX,
    parameter int DEPTH = `AICD_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic [NUM_TX-1:0] tx_fifo_empty_evt,
    input wire logic [NUM_TX-1:0] tx_end_evt,
    input wire logic [NUM_TX-1:0] tx_one_bit,
    input wire logic [NUM_TX-1:0] tx_zero_bit,
    input wire logic [NUM_RX-1:0] rx_valid_evt,
    input wire logic rx_parity_evt,
    input wire logic [NUM_RX-1:0] rx_one_line,
    input wire logic [NUM_RX-1:0] rx_zero_line,
    output logic [NUM_RX-1:0] rx_one_seen,
    output logic [NUM_RX-1:0] rx_zero_seen,
    output logic [NUM_TX-1:0] tx_one_line,
    output logic [NUM_TX-1:0] tx_zero_line,
    input wire logic tx_chain_enable_in_n,
    output logic tx_chain_enable_out_n,
    input wire logic rx_chain_enable_in_n,
    output logic rx_chain_enable_out_n,
    output logic tx_irq_request_n_o,
    output logic tx_irq_request_n_oe,
    output logic rx_irq_request_n_o,
    output logic rx_irq_request_n_oe,
    input wire logic tx_irq_ack_n,
    input wire logic rx_irq_ack_n,
    output logic transfer_ack_n,
    output logic [15:0] data_o,
    output logic data_oe
);
    import aicd_pkg::*;
    // vector index is four bits wide, so cause counts are fixed
    if (NUM_TX != `AICD_NUM_TX || NUM_RX != `AICD_NUM_RX) begin : g_bad_count
        $error("channel counts fixed");
    end
    localparam int TXC = 2 * NUM_TX;
    localparam int RXC = NUM_RX + 1;

    logic [TXC-1:0] tx_pend_q;
    logic [RXC-1:0] rx_pend_q;
    logic [4:0] div_q;
    logic ser_en_q;
    aicd_ack_e st_q;
    logic ack_rx_q;
    logic [7:0] vec_q;
    logic tx_eo_q, rx_eo_q, tx_rq_q, rx_rq_q, xfer_ack_q, doe_q;
    logic [15:0] dout_q;
    logic [NUM_TX-1:0] tx1_q, tx0_q;
    logic [NUM_RX-1:0] rx1_q, rx0_q;

    // causes: tx bit 2i fifo empty, 2i+1 end of transmission
    logic [TXC-1:0] tx_set;
    logic [RXC-1:0] rx_set;
    for (genvar i = 0; i < NUM_TX; i++) begin : g_txc
        assign tx_set[2*i] = tx_fifo_empty_evt[i]; // R12
        assign tx_set[2*i+1] = tx_end_evt[i]; // R12
    end
    assign rx_set = {rx_parity_evt, rx_valid_evt}; // R3

    wire tx_any = |tx_pend_q;
    wire rx_any = |rx_pend_q;
    // lowest index wins; a pending device also blocks the chain below it
    wire tx_grant = !tx_chain_enable_in_n && tx_any && !tx_irq_ack_n; // R1
    wire rx_grant = !rx_chain_enable_in_n && rx_any && !rx_irq_ack_n; // R5
    logic [3:0] tx_idx, rx_idx;
    always_comb begin
        tx_idx = '0;
        for (int k = TXC - 1; k >= 0; k--) if (tx_pend_q[k]) tx_idx = 4'(k);
        rx_idx = '0;
        for (int k = RXC - 1; k >= 0; k--) if (rx_pend_q[k]) rx_idx = 4'(k);
    end
    wire [7:0] tx_vec = `AICD_TX_VEC_BASE + {4'h0, tx_idx};
    wire [7:0] rx_vec = `AICD_RX_VEC_BASE + {4'h0, rx_idx};
    wire start_ack = (st_q == AICD_IDLE) && (tx_grant || rx_grant);
    wire pick_rx = rx_grant && !tx_grant;
    wire [TXC-1:0] tx_clr = (start_ack && !pick_rx) ? TXC'(1) << tx_idx : '0;
    wire [RXC-1:0] rx_clr = (start_ack && pick_rx) ? RXC'(1) << rx_idx : '0;

    // serial-rate enable; limitation: a divided enable, not a second clock
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin // R8
            div_q <= '0;
            ser_en_q <= 1'b0;
        end else begin
            div_q <= (div_q == 5'(`AICD_SER_DIV - 1)) ? '0 : div_q + 5'h1;
            ser_en_q <= (div_q == 5'(`AICD_SER_DIV - 1)); // R10
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_pend_q <= '0;
            rx_pend_q <= '0;
        end else begin
            // set beats clear so an event during acknowledge is kept
            tx_pend_q <= (tx_pend_q & ~tx_clr) | tx_set;
            rx_pend_q <= (rx_pend_q & ~rx_clr) | rx_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_eo_q <= 1'b1;
            rx_eo_q <= 1'b1;
            tx_rq_q <= 1'b0;
            rx_rq_q <= 1'b0;
        end else begin
            tx_eo_q <= !(!tx_chain_enable_in_n && !tx_any); // R2
            rx_eo_q <= !(!rx_chain_enable_in_n && !rx_any); // R5
            tx_rq_q <= tx_any; // R12 R14
            rx_rq_q <= rx_any; // R3 R14
        end
    end

    // acknowledge: one vector per ack, then wait for ack release
    wire ack_done = tx_irq_ack_n && rx_irq_ack_n && chip_select_n;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= AICD_IDLE;
            ack_rx_q <= 1'b0;
            vec_q <= '0;
        end else begin
            case (st_q)
                AICD_IDLE: if (start_ack) begin // R9
                    st_q <= AICD_ACK;
                    ack_rx_q <= pick_rx;
                    vec_q <= pick_rx ? rx_vec : tx_vec; // R4
                end
                AICD_ACK: st_q <= AICD_HOLD;
                AICD_HOLD: if (ack_done) st_q <= AICD_IDLE;
                default: st_q <= AICD_IDLE;
            endcase
        end
    end

    logic f_rdy, f_vld;
    logic [7:0] f_data;
    aicd_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(st_q == AICD_ACK),
        .in_ready(f_rdy),
        .in_data(vec_q),
        .out_valid(f_vld),
        .out_ready(1'b1),
        .out_data(f_data)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            xfer_ack_q <= 1'b1;
            doe_q <= 1'b0;
            dout_q <= '0;
        end else begin
            xfer_ack_q <= !(!chip_select_n || f_vld); // R13
            doe_q <= f_vld;
            dout_q <= f_vld ? {8'h00, f_data} : '0; // R11
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx1_q <= '0;
            tx0_q <= '0;
            rx1_q <= '0;
            rx0_q <= '0;
        end else if (ser_en_q) begin
            tx1_q <= tx_one_bit & ~tx_zero_bit; // R6
            tx0_q <= tx_zero_bit & ~tx_one_bit; // R6
            rx1_q <= rx_one_line; // R7
            rx0_q <= rx_zero_line; // R7
        end
    end

    assign tx_one_line = tx1_q;
    assign tx_zero_line = tx0_q;
    assign rx_one_seen = rx1_q;
    assign rx_zero_seen = rx0_q;
    assign tx_chain_enable_out_n = tx_eo_q;
    assign rx_chain_enable_out_n = rx_eo_q;
    assign tx_irq_request_n_o = 1'b0;
    assign rx_irq_request_n_o = 1'b0;
    // enable low means driving low
    assign tx_irq_request_n_oe = !tx_rq_q;
    assign rx_irq_request_n_oe = !rx_rq_q;
    assign transfer_ack_n = xfer_ack_q;
    assign data_o = dout_q;
    assign data_oe = doe_q;

    chk_tx_chain_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
        (!tx_chain_enable_in_n && !tx_any) |=> !tx_chain_enable_out_n)
        else $error("tx chain out not passed");
    chk_tx_chain_block: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
        tx_any |=> tx_chain_enable_out_n)
        else $error("tx chain passed while pending");
    chk_rx_chain_out: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        rx_any |=> rx_chain_enable_out_n)
        else $error("rx chain passed while pending");
    chk_rx_req_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
        $rose(rx_parity_evt) |=> ##1 !rx_irq_request_n_oe)
        else $error("rx request missing");
    chk_tx_req_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        (|tx_set) |=> ##1 !tx_irq_request_n_oe)
        else $error("tx request missing");
    chk_req_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        !rx_any |=> rx_irq_request_n_oe)
        else $error("rx request not released");
    chk_tx_req_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        !tx_any |=> tx_irq_request_n_oe)
        else $error("tx request not released");
    chk_vec_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
        data_oe |-> data_o[15:8] == 8'h00)
        else $error("vector upper byte not zero");
    chk_ack_xfer: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        (st_q == AICD_IDLE && start_ack) |-> ##[2:4] !transfer_ack_n)
        else $error("no transfer ack on acknowledge");
    chk_rx_vec: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        (start_ack && pick_rx) |=> ack_rx_q && vec_q == $past(rx_vec))
        else $error("wrong rx vector");
    chk_fifo_room: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        (st_q == AICD_ACK) |-> f_rdy)
        else $error("vector fifo full on push");
    cov_tx_ack: cover property (@(posedge ref_clk) start_ack && !pick_rx);
    cov_rx_ack: cover property (@(posedge ref_clk) start_ack && pick_rx);
    cov_cs: cover property (@(posedge ref_clk) !chip_select_n ##1 !transfer_ack_n);
endmodule : aicd_top

//--- common/aicd_consts.svh
// Purpose: constants for the interrupt daisy-chain controller
// Assumes: one 25 MHz clock (40 ns period)
// Notes: vector bases are arbitrary defaults
`ifndef AICD_CONSTS_SVH
`define AICD_CONSTS_SVH
`define AICD_NUM_TX 3
`define AICD_NUM_RX 8
`define AICD_TX_CAUSES 6
`define AICD_RX_CAUSES 9
`define AICD_VEC_W 8
`define AICD_TX_VEC_BASE 8'h40
`define AICD_RX_VEC_BASE 8'h80
`define AICD_FIFO_DEPTH 16
`define AICD_SER_DIV 25
`endif

//--- common/aicd_pkg.sv
// Purpose: types for the interrupt daisy-chain controller
// Assumes: constants come from aicd_consts.svh
// Notes: none
package aicd_pkg;
    typedef enum logic [1:0] {AICD_IDLE, AICD_ACK, AICD_HOLD} aicd_ack_e;
    typedef logic [7:0] aicd_vec_t;
endpackage : aicd_pkg

//--- hw/aicd_fifo.sv
// Purpose: vector fifo between acknowledge logic and data bus driver
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact
`timescale 1ns/1ps
module aicd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // pointers wrap by bit width, so only powers of two are served
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (push) mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule : aicd_fifo

//--- sim/aicd_host_model.sv
// Purpose: host side partner: pull-ups on request wires, acknowledge handshake
// Assumes: request wires have pull-ups on the board
// Notes: acknowledge is held until transfer ack is sampled low with data_oe high, for at most 8 clocks
`timescale 1ns/1ps
module aicd_host_model (
    input wire logic ref_clk,
    input wire logic tx_irq_request_n_o,
    input wire logic tx_irq_request_n_oe,
    input wire logic rx_irq_request_n_o,
    input wire logic rx_irq_request_n_oe,
    input wire logic transfer_ack_n,
    input wire logic [15:0] data_o,
    input wire logic data_oe,
    output logic tx_req_wire_n,
    output logic rx_req_wire_n,
    output logic tx_irq_ack_n,
    output logic rx_irq_ack_n
);
    // a released request floats to the pull-up level, never to a stale value
    assign tx_req_wire_n = tx_irq_request_n_oe ? 1'b1 : tx_irq_request_n_o;
    assign rx_req_wire_n = rx_irq_request_n_oe ? 1'b1 : rx_irq_request_n_o;
    initial begin
        tx_irq_ack_n = 1'b1;
        rx_irq_ack_n = 1'b1;
    end
    task automatic ack(input logic rx, output logic [15:0] vec, output logic got);
        int n;
        got = 1'b0;
        vec = 16'hffff;
        @(posedge ref_clk);
        #2;
        if (rx) rx_irq_ack_n = 1'b0; else tx_irq_ack_n = 1'b0;
        for (n = 0; n < 8 && !got; n++) begin
            @(posedge ref_clk);
            if (transfer_ack_n === 1'b0 && data_oe === 1'b1) begin
                got = 1'b1;
                vec = data_o;
            end
        end
        #2;
        tx_irq_ack_n = 1'b1;
        rx_irq_ack_n = 1'b1;
    endtask : ack
endmodule : aicd_host_model

//--- sim/test_arinc_ctrl_irq_daisy_chain.sv
// Purpose: self-checking bench for the interrupt daisy-chain controller
// Assumes: inputs change 2 ns after the rising edge
// Notes: serial outputs are given 30 clocks, above one serial step
`include "aicd_consts.svh"
`timescale 1ns/1ps
module test_arinc_ctrl_irq_daisy_chain;
    import aicd_pkg::*;
    logic ref_clk, rst_n, chip_select_n, tx_chain_enable_in_n, rx_chain_enable_in_n;
    logic rx_parity_evt, tx_chain_enable_out_n, rx_chain_enable_out_n, transfer_ack_n, data_oe;
    logic [2:0] tx_fifo_empty_evt, tx_end_evt, tx_one_bit, tx_zero_bit, tx_one_line, tx_zero_line;
    logic [7:0] rx_valid_evt, rx_one_line, rx_zero_line, rx_one_seen, rx_zero_seen;
    logic tx_o, tx_oe, rx_o, rx_oe, tx_req_n, rx_req_n, tx_irq_ack_n, rx_irq_ack_n, got;
    logic [15:0] data_o, vec;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    aicd_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .chip_select_n(chip_select_n),
        .tx_fifo_empty_evt(tx_fifo_empty_evt), .tx_end_evt(tx_end_evt),
        .tx_one_bit(tx_one_bit), .tx_zero_bit(tx_zero_bit), .rx_valid_evt(rx_valid_evt),
        .rx_parity_evt(rx_parity_evt), .rx_one_line(rx_one_line), .rx_zero_line(rx_zero_line),
        .rx_one_seen(rx_one_seen), .rx_zero_seen(rx_zero_seen), .tx_one_line(tx_one_line),
        .tx_zero_line(tx_zero_line), .tx_chain_enable_in_n(tx_chain_enable_in_n),
        .tx_chain_enable_out_n(tx_chain_enable_out_n),
        .rx_chain_enable_in_n(rx_chain_enable_in_n),
        .rx_chain_enable_out_n(rx_chain_enable_out_n), .tx_irq_request_n_o(tx_o),
        .tx_irq_request_n_oe(tx_oe), .rx_irq_request_n_o(rx_o), .rx_irq_request_n_oe(rx_oe),
        .tx_irq_ack_n(tx_irq_ack_n), .rx_irq_ack_n(rx_irq_ack_n),
        .transfer_ack_n(transfer_ack_n), .data_o(data_o), .data_oe(data_oe));
    aicd_host_model i_host (.ref_clk(ref_clk), .tx_irq_request_n_o(tx_o),
        .tx_irq_request_n_oe(tx_oe), .rx_irq_request_n_o(rx_o), .rx_irq_request_n_oe(rx_oe),
        .transfer_ack_n(transfer_ack_n), .data_o(data_o), .data_oe(data_oe),
        .tx_req_wire_n(tx_req_n), .rx_req_wire_n(rx_req_n), .tx_irq_ack_n(tx_irq_ack_n),
        .rx_irq_ack_n(rx_irq_ack_n));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // 5000 clocks is far beyond the hundred or so the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : step
    task automatic t_reset();
        check("tx chain out", 16'(tx_chain_enable_out_n), 16'h0001);
        check("rx request", 16'(rx_req_n), 16'h0001);
        check("transfer ack", 16'(transfer_ack_n), 16'h0001);
        check("data oe", 16'(data_oe), 16'h0000);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_tx();
        tx_end_evt = 3'h2;
        tx_fifo_empty_evt = 3'h4;
        step(1);
        tx_end_evt = 3'h0;
        tx_fifo_empty_evt = 3'h0;
        step(3);
        check("tx request", 16'(tx_req_n), 16'h0000);
        check("tx chain out busy", 16'(tx_chain_enable_out_n), 16'h0001);
        check("rx chain out", 16'(rx_chain_enable_out_n), 16'h0000);
        i_host.ack(1'b0, vec, got);
        check("tx ack 1", {15'h0000, got}, 16'h0001);
        check("tx vector 1", vec, 16'h0043);
        i_host.ack(1'b0, vec, got);
        check("tx vector 2", vec, 16'h0044);
        step(4);
        check("tx request off", 16'(tx_req_n), 16'h0001);
        check("tx chain out pass", 16'(tx_chain_enable_out_n), 16'h0000);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx();
        rx_chain_enable_in_n = 1'b1;
        rx_valid_evt = 8'h20;
        rx_parity_evt = 1'b1;
        step(1);
        rx_valid_evt = 8'h00;
        rx_parity_evt = 1'b0;
        step(3);
        check("rx request", 16'(rx_req_n), 16'h0000);
        check("rx chain out", 16'(rx_chain_enable_out_n), 16'h0001);
        i_host.ack(1'b1, vec, got);
        check("rx ack blocked", {15'h0000, got}, 16'h0000);
        rx_chain_enable_in_n = 1'b0;
        i_host.ack(1'b1, vec, got);
        check("rx vector 1", vec, 16'h0085);
        i_host.ack(1'b1, vec, got);
        check("rx vector 2", vec, 16'h0088);
        step(4);
        check("rx request off", 16'(rx_req_n), 16'h0001);
        $display("t_rx done");
    endtask : t_rx
    task automatic t_mid_reset();
        rx_valid_evt = 8'h01;
        step(1);
        rx_valid_evt = 8'h00;
        step(3);
        check("rx request set", 16'(rx_req_n), 16'h0000);
        rst_n = 1'b0;
        step(2);
        check("rx request reset", 16'(rx_req_n), 16'h0001);
        check("rx chain out reset", 16'(rx_chain_enable_out_n), 16'h0001);
        rst_n = 1'b1;
        step(2);
        check("rx chain out after", 16'(rx_chain_enable_out_n), 16'h0000);
        i_host.ack(1'b1, vec, got);
        check("ack after reset", {15'h0000, got}, 16'h0000);
        $display("t_mid_reset done");
    endtask : t_mid_reset
    task automatic t_cs();
        chip_select_n = 1'b0;
        step(2);
        check("cs transfer ack", 16'(transfer_ack_n), 16'h0000);
        chip_select_n = 1'b1;
        step(2);
        check("cs ack off", 16'(transfer_ack_n), 16'h0001);
        $display("t_cs done");
    endtask : t_cs
    task automatic t_lines();
        tx_one_bit = 3'h5;
        tx_zero_bit = 3'h2;
        rx_one_line = 8'ha5;
        rx_zero_line = 8'h5a;
        step(30);
        check("tx one", 16'(tx_one_line), 16'h0005);
        check("tx zero", 16'(tx_zero_line), 16'h0002);
        check("rx one", 16'(rx_one_seen), 16'h00a5);
        check("rx zero", 16'(rx_zero_seen), 16'h005a);
        $display("t_lines done");
    endtask : t_lines
    initial begin
        rst_n = 1'b0;
        chip_select_n = 1'b1;
        tx_chain_enable_in_n = 1'b0;
        rx_chain_enable_in_n = 1'b0;
        tx_fifo_empty_evt = 3'h0;
        tx_end_evt = 3'h0;
        tx_one_bit = 3'h0;
        tx_zero_bit = 3'h0;
        rx_valid_evt = 8'h00;
        rx_parity_evt = 1'b0;
        rx_one_line = 8'h00;
        rx_zero_line = 8'h00;
        step(6);
        t_reset();
        rst_n = 1'b1;
        step(1);
        t_tx();
        t_rx();
        t_mid_reset();
        t_cs();
        t_lines();
        end_of_test();
    end
endmodule : test_arinc_ctrl_irq_daisy_chain
